// File: hdl/scd_pkg.sv
// register map, field layout and carriers of the clock select and divide block
`default_nettype none
package scd_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] SRC_DIV_INDEX      = 12'h0a9;
    localparam logic [11:0] SLOW_CTRL_INDEX    = 12'h0b1;
    localparam logic [11:0] FAST_TRIM_INDEX    = 12'h0c7;
    localparam logic [11:0] SRC_DIV_ADDR       = 12'(SRC_DIV_INDEX * 4);
    localparam logic [11:0] SLOW_CTRL_ADDR     = 12'(SLOW_CTRL_INDEX * 4);
    localparam logic [11:0] FAST_TRIM_ADDR     = 12'(FAST_TRIM_INDEX * 4);
    // clock_source_and_divider fields
    localparam int          DIV_LSB            = 4;
    localparam int          DIV_MSB            = 6;
    localparam int          SRC_LSB            = 0;
    localparam int          SRC_MSB            = 1;
    localparam logic [2:0]  DIV_RESET          = 3'h3;
    localparam logic [1:0]  SRC_RESET          = 2'h0;
    localparam logic [7:0]  SRC_DIV_WMASK      = 8'h73;
    // slow_osc_control fields, then the source field codes
    localparam int          SLOW_EN_BIT        = 7;
    localparam int          SLOW_SETTLED_BIT   = 6;
    localparam int          TUNE_LSB           = 2;
    localparam int          TUNE_MSB           = 5;
    localparam int          SLDIV_LSB          = 0;
    localparam int          SLDIV_MSB          = 1;
    localparam logic [1:0]  SLDIV_RESET        = 2'h0;
    localparam logic [1:0]  SRC_FAST           = 2'h0;
    localparam logic [1:0]  SRC_EXT            = 2'h1;
    localparam logic [1:0]  SRC_SLOW           = 2'h2;
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } scd_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scd_apb_rsp_t;
endpackage
`default_nettype wire

// File: hdl/scd_clock_select.sv
// system clock source select, programmable divider, slow oscillator divider and capture
// How it works
// - reset selects the fast oscillator divided by eight
// - divider field bits 6:4 divides the source by two to the code
// - source field bits 1:0 picks fast, external pin or slow oscillator
// - source may change while running; software picks only settled sources
// - a new divider setting is accepted at any time
// - the external pin is resynchronised to the system clock
// - the fast oscillator is enabled automatically whenever it is requested
// - software writes the fast oscillator trim register
// - slow oscillator has its own divider by 1, 2, 4 or 8
// - a tuning field coarsely adjusts the slow oscillator frequency
// - slow oscillator selectable right after the write that enables it
// - each slow output falling edge in capture mode pulses a capture event
// - external pin serves as core clock or as a peripheral clock
// - trim 0x00 fastest, 0xff slowest, factory value back on reset
// - read-only bit 6 reads one when the slow oscillator has settled
// - slow tuning is a four-bit read-write field at bits 5:2
//
// Added by the designer: the APB register port.
`default_nettype none
module scd_clock_select #(
    parameter logic [7:0] TRIM_FACTORY = 8'h80,
    parameter logic [3:0] TUNE_FACTORY = 4'h8
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire scd_pkg::scd_apb_req_t apbReq,
    output var  scd_pkg::scd_apb_rsp_t apbRsp,
    input  wire logic                  fastInternalOsc,
    input  wire logic                  slowInternalOsc,
    input  wire logic                  externalClockPin,
    input  wire logic                  slowOscSettled,
    input  wire logic                  fastOscPeriphRequest,
    input  wire logic                  slowCaptureMode,
    output logic                       systemClockOut,
    output logic                       fastOscEnable,
    output logic [7:0]                 fastOscTrim,
    output logic                       slowOscEnable,
    output logic [3:0]                 slowOscTune,
    output logic                       slowOscDivided,
    output logic                       externalClockSync,
    output logic                       slowCaptureEvent
);
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  divSetting;
        logic [1:0]  srcChoice;
        logic [2:0]  activeDiv;
        logic [1:0]  activeSrc;
        logic [7:0]  trim;
        logic        slowEn;
        logic [3:0]  tune;
        logic [1:0]  slowDiv;
        logic [2:0]  slowCnt;
        logic        slowPrev;
        logic        slowOut;
        logic        slowOutPrev;
        logic        capture;
        logic        extMeta;
        logic        extSync;
        logic        srcPrev;
        logic [6:0]  sysCnt;
        logic        sysOut;
        logic        fastEn;
    } scd_state_t;

    scd_state_t cur;
    scd_state_t next_cur;

    // the state fields are sized for the package field layout
    if (scd_pkg::DIV_MSB - scd_pkg::DIV_LSB != 2 || scd_pkg::SRC_MSB - scd_pkg::SRC_LSB != 1
        || scd_pkg::TUNE_MSB - scd_pkg::TUNE_LSB != 3
        || scd_pkg::SLDIV_MSB - scd_pkg::SLDIV_LSB != 1) begin : gBadParam
        $error("scd_clock_select: field layout does not fit the state");
    end

    // edges of the selected source between two toggles of the output
    function automatic logic [6:0] halfMask(input logic [2:0] n);
        halfMask = (n == 3'h0) ? 7'h00 : 7'((8'h01 << (n - 3'h1)) - 8'h01);
    endfunction

    function automatic logic [7:0] selectRead(input scd_state_t s);
        selectRead = 8'h00;
        selectRead[scd_pkg::DIV_MSB:scd_pkg::DIV_LSB] = s.divSetting;
        selectRead[scd_pkg::SRC_MSB:scd_pkg::SRC_LSB] = s.srcChoice;
    endfunction

    // register picked by an apb byte address
    typedef enum {
        SCD_REG_SRC_DIV,
        SCD_REG_SLOW_CTRL,
        SCD_REG_FAST_TRIM,
        SCD_REG_NONE
    } scd_reg_t;

    function automatic scd_reg_t decodeReg(input logic [11:0] addr);
        case (addr)
            scd_pkg::SRC_DIV_ADDR: begin
                decodeReg = SCD_REG_SRC_DIV;
            end
            scd_pkg::SLOW_CTRL_ADDR: begin
                decodeReg = SCD_REG_SLOW_CTRL;
            end
            scd_pkg::FAST_TRIM_ADDR: begin
                decodeReg = SCD_REG_FAST_TRIM;
            end
            default: begin
                decodeReg = SCD_REG_NONE;
            end
        endcase
    endfunction

    // source codes other than external and slow run from the fast oscillator
    function automatic logic isFastSrc(input logic [1:0] src);
        isFastSrc = (src != scd_pkg::SRC_EXT) && (src != scd_pkg::SRC_SLOW);
    endfunction

    // tap of the slow oscillator divider for a divider code
    function automatic logic slowTap(input logic [1:0] code, input logic raw, input logic [2:0] cnt);
        case (code)
            2'h0: begin
                slowTap = raw;
            end
            2'h1: begin
                slowTap = cnt[0];
            end
            2'h2: begin
                slowTap = cnt[1];
            end
            default: begin
                slowTap = cnt[2];
            end
        endcase
    endfunction

    // slow control read image; the settled flag comes from the oscillator
    function automatic logic [7:0] slowRead(input scd_state_t s, input logic settled);
        slowRead = 8'h00;
        slowRead[scd_pkg::SLOW_EN_BIT] = s.slowEn;
        slowRead[scd_pkg::SLOW_SETTLED_BIT] = settled;
        slowRead[scd_pkg::TUNE_MSB:scd_pkg::TUNE_LSB] = s.tune;
        slowRead[scd_pkg::SLDIV_MSB:scd_pkg::SLDIV_LSB] = s.slowDiv;
    endfunction

    logic     srcLevel;
    logic     srcRise;
    logic     setupCycle;
    logic     writeAccess;
    scd_reg_t regSel;

    // apb phases and the register that the address picks
    always_comb begin
        setupCycle = apbReq.psel && !apbReq.penable;
        // a write is taken at the access edge, while pready stands
        writeAccess = apbReq.psel && apbReq.penable && cur.pready && apbReq.pwrite;
        regSel = decodeReg(apbReq.paddr);
    end

    always_comb begin
        case (cur.activeSrc)
            scd_pkg::SRC_EXT:  srcLevel = cur.extSync;
            scd_pkg::SRC_SLOW: srcLevel = cur.slowOut;
            default:           srcLevel = fastInternalOsc;
        endcase
        srcRise = srcLevel & ~cur.srcPrev;
    end

    always_comb begin
        next_cur = cur;
        next_cur.capture = 1'b0;
        // apb slave: one access cycle, answered by a registered pready
        next_cur.pready = 1'b0;
        if (setupCycle) begin
            next_cur.pready = 1'b1;
            next_cur.pslverr = 1'b0;
            next_cur.prdata = 32'h0000_0000;
            case (regSel)
                SCD_REG_SRC_DIV: begin
                    next_cur.prdata[7:0] = selectRead(cur);
                end
                SCD_REG_SLOW_CTRL: begin
                    next_cur.prdata[7:0] = slowRead(cur, slowOscSettled);
                end
                SCD_REG_FAST_TRIM: begin
                    next_cur.prdata[7:0] = cur.trim;
                end
                default: begin
                    next_cur.pslverr = 1'b1;
                end
            endcase
        end
        if (writeAccess) begin
            case (regSel)
                SCD_REG_SRC_DIV: begin
                    next_cur.divSetting = apbReq.pwdata[scd_pkg::DIV_MSB:scd_pkg::DIV_LSB];
                    next_cur.srcChoice = apbReq.pwdata[scd_pkg::SRC_MSB:scd_pkg::SRC_LSB];
                end
                SCD_REG_SLOW_CTRL: begin
                    // enable takes effect with no start-up wait
                    next_cur.slowEn = apbReq.pwdata[scd_pkg::SLOW_EN_BIT];
                    next_cur.tune = apbReq.pwdata[scd_pkg::TUNE_MSB:scd_pkg::TUNE_LSB];
                    next_cur.slowDiv = apbReq.pwdata[scd_pkg::SLDIV_MSB:scd_pkg::SLDIV_LSB];
                end
                SCD_REG_FAST_TRIM: begin
                    next_cur.trim = apbReq.pwdata[7:0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end

        // two-flop resynchroniser of the external pin
        next_cur.extMeta = externalClockPin;
        next_cur.extSync = cur.extMeta;

        next_cur.slowPrev = slowInternalOsc;
        if (slowInternalOsc && !cur.slowPrev) begin
            next_cur.slowCnt = cur.slowCnt + 3'h1;
        end
        next_cur.slowOut = slowTap(cur.slowDiv, slowInternalOsc, cur.slowCnt);
        // capture pulse on falling edge of divided slow output
        next_cur.slowOutPrev = cur.slowOut;
        next_cur.capture = slowCaptureMode && cur.slowOutPrev && !cur.slowOut;

        // divide by two to the code
        next_cur.srcPrev = srcLevel;
        if (cur.activeDiv == 3'h0) begin
            next_cur.sysOut = srcLevel;
            // switch only at the end of a full low phase
            if (srcRise && !cur.sysOut) begin
                next_cur.activeDiv = cur.divSetting;
                next_cur.activeSrc = cur.srcChoice;
                next_cur.sysCnt = 7'h00;
            end
        end else if (srcRise) begin
            if ((cur.sysCnt & halfMask(cur.activeDiv)) == halfMask(cur.activeDiv)) begin
                next_cur.sysCnt = 7'h00;
                next_cur.sysOut = ~cur.sysOut;
                // new settings adopted as a full low phase ends
                if (!cur.sysOut) begin
                    next_cur.activeDiv = cur.divSetting;
                    next_cur.activeSrc = cur.srcChoice;
                    if (cur.divSetting == 3'h0) begin
                        next_cur.sysOut = 1'b0;
                    end
                end
            end else begin
                next_cur.sysCnt = cur.sysCnt + 7'h01;
            end
        end

        next_cur.fastEn = isFastSrc(cur.activeSrc)
                          || isFastSrc(cur.srcChoice)
                          || fastOscPeriphRequest;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
            cur.divSetting <= scd_pkg::DIV_RESET;
            cur.activeDiv <= scd_pkg::DIV_RESET;
            cur.srcChoice <= scd_pkg::SRC_RESET;
            cur.activeSrc <= scd_pkg::SRC_RESET;
            cur.trim <= TRIM_FACTORY;
            cur.tune <= TUNE_FACTORY;
            cur.slowDiv <= scd_pkg::SLDIV_RESET;
            cur.fastEn <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // external pin offered to peripherals when resynchronised
    assign externalClockSync = cur.extSync;
    assign apbRsp = '{prdata: cur.prdata, pready: cur.pready, pslverr: cur.pslverr};
    assign systemClockOut = cur.sysOut;
    assign fastOscEnable = cur.fastEn;
    assign fastOscTrim = cur.trim;
    assign slowOscEnable = cur.slowEn;
    // coarse tuning driven to the oscillator
    assign slowOscTune = cur.tune;
    assign slowOscDivided = cur.slowOut;
    assign slowCaptureEvent = cur.capture;
endmodule
`default_nettype wire

// File: verification/scd_clock_select_assertions.sv
// concurrent checks on the clock select block ports
`default_nettype none
module scd_clock_select_checker (
    input wire logic                  core_clk,
    input wire logic                  rst_b,
    input wire scd_pkg::scd_apb_req_t apbReq,
    input wire scd_pkg::scd_apb_rsp_t apbRsp,
    input wire logic                  fastOscPeriphRequest,
    input wire logic                  slowCaptureMode,
    input wire logic                  externalClockPin,
    input wire logic                  fastOscEnable,
    input wire logic [7:0]            fastOscTrim,
    input wire logic                  slowOscDivided,
    input wire logic                  slowCaptureEvent,
    input wire logic                  externalClockSync
);
    logic mapped;
    assign mapped = apbReq.paddr inside {scd_pkg::SRC_DIV_ADDR, scd_pkg::SLOW_CTRL_ADDR, scd_pkg::FAST_TRIM_ADDR};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_setup; apbReq.psel && !apbReq.penable; endsequence
    sequence s_trim_wr; apbRsp.pready && apbReq.pwrite && apbReq.paddr == scd_pkg::FAST_TRIM_ADDR; endsequence
    property p_ready_next; s_setup |=> apbRsp.pready; endproperty
    property p_ready_pulse; apbRsp.pready |=> !apbRsp.pready; endproperty
    property p_err_map; apbRsp.pready |-> apbRsp.pslverr == !mapped; endproperty
    property p_upper_zero; apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0; endproperty
    property p_trim_wr; s_trim_wr |=> fastOscTrim == $past(apbReq.pwdata[7:0]); endproperty
    property p_capture; $fell(slowOscDivided) && slowCaptureMode |=> slowCaptureEvent; endproperty
    property p_capture_cause; slowCaptureEvent |-> $past(slowCaptureMode); endproperty
    property p_fast_req; fastOscPeriphRequest |=> fastOscEnable; endproperty
    property p_ext_sync; $rose(externalClockSync) |-> $past(externalClockPin, 2) || $past(externalClockPin, 3); endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
    a_trim_wr: assert property (p_trim_wr) else $error("trim not written");
    a_capture: assert property (p_capture) else $error("capture event missing");
    a_capture_cause: assert property (p_capture_cause) else $error("capture outside capture mode");
    a_fast_req: assert property (p_fast_req) else $error("fast oscillator not enabled");
    a_ext_sync: assert property (p_ext_sync) else $error("external clock not resynchronised");
endmodule
bind scd_clock_select scd_clock_select_checker u_scd_clock_select_checker (
    .core_clk, .rst_b, .apbReq, .apbRsp, .fastOscPeriphRequest, .slowCaptureMode, .externalClockPin,
    .fastOscEnable, .fastOscTrim, .slowOscDivided, .slowCaptureEvent, .externalClockSync);
`default_nettype wire

// File: verification/scd_clock_select_bench.sv
// self-checking bench for the clock select block
`default_nettype none
module scd_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  core_clk = 1'b0;
    logic                  rst_b = 1'b0;
    scd_pkg::scd_apb_req_t apbReq = '0;
    scd_pkg::scd_apb_rsp_t apbRsp;
    logic [2:0]            cyc = 3'h0;
    logic                  settled = 1'b1;
    logic                  fastReq = 1'b0;
    logic                  capMode = 1'b0;
    logic                  sysOut, fastEn, slowEn, slowDiv, capEv, err, extSync;
    logic [7:0]            trim, rd;
    logic [3:0]            tune;
    int                    n_errors = 0;
    int                    n_compared = 0;
    int                    hi, lo, n;
    always #25 core_clk = ~core_clk;
    // sources: fast period 2, external 4, slow 8 cycles
    always @(posedge core_clk) cyc <= cyc + 3'h1;
    scd_clock_select u_scd_clock_select (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
        .fastInternalOsc(cyc[0]), .slowInternalOsc(cyc[2]), .externalClockPin(cyc[1]), .slowOscSettled(settled),
        .fastOscPeriphRequest(fastReq), .slowCaptureMode(capMode), .systemClockOut(sysOut), .fastOscEnable(fastEn),
        .fastOscTrim(trim), .slowOscEnable(slowEn), .slowOscTune(tune), .slowOscDivided(slowDiv),
        .externalClockSync(extSync), .slowCaptureEvent(capEv));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (apbRsp.pready !== 1'b1 && k < 20);
        chk(32'(apbRsp.pready), 32'h1);
        rd = apbRsp.prdata[7:0];
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // high and low phase lengths of the system clock, in core cycles
    task automatic meas;
        int k;
        k = 0;
        hi = 0;
        lo = 0;
        while (sysOut !== 1'b0 && k < 999) begin
            @(posedge core_clk);
            k++;
        end
        while (sysOut !== 1'b1 && k < 999) begin
            @(posedge core_clk);
            k++;
        end
        while (sysOut === 1'b1 && k < 999) begin
            @(posedge core_clk);
            hi++;
            k++;
        end
        while (sysOut === 1'b0 && k < 999) begin
            @(posedge core_clk);
            lo++;
            k++;
        end
    endtask
    task automatic t_reset;
        apb(scd_pkg::SRC_DIV_ADDR, 1'b0, 8'h0);
        chk(rd, 8'h30);
        apb(scd_pkg::FAST_TRIM_ADDR, 1'b0, 8'h0);
        chk(rd, 8'h80);
        apb(scd_pkg::SLOW_CTRL_ADDR, 1'b0, 8'h0);
        chk(rd, 8'h60);
        chk(fastEn, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_regs;
        apb(scd_pkg::SRC_DIV_ADDR, 1'b1, 8'hff);
        apb(scd_pkg::SRC_DIV_ADDR, 1'b0, 8'h0);
        chk(rd, 8'h73);
        apb(12'h004, 1'b1, 8'h55);
        chk(err, 1'b1);
        for (int i = 0; i < 2; i++) begin
            apb(scd_pkg::FAST_TRIM_ADDR, 1'b1, i ? 8'hff : 8'h00);
            apb(scd_pkg::FAST_TRIM_ADDR, 1'b0, 8'h0);
            chk(rd, i ? 8'hff : 8'h00);
            chk(trim, i ? 8'hff : 8'h00);
        end
        settled <= 1'b0;
        apb(scd_pkg::SLOW_CTRL_ADDR, 1'b1, 8'hff);
        apb(scd_pkg::SLOW_CTRL_ADDR, 1'b0, 8'h0);
        chk(rd, 8'hbf);
        chk({slowEn, tune}, 5'h1f);
        settled <= 1'b1;
        $display("test registers done");
    endtask
    task automatic t_divide;
        for (int c = 0; c < 8; c++) begin
            apb(scd_pkg::SRC_DIV_ADDR, 1'b1, {1'b0, 3'(c), 4'h0});
            meas;
            meas;
            chk(hi, 1 << c);
            chk(lo, 1 << c);
        end
        $display("test divide done");
    endtask
    task automatic t_select;
        logic [2:0] lag;
        // slow oscillator enabled before it is picked
        apb(scd_pkg::SLOW_CTRL_ADDR, 1'b1, 8'h80);
        // the external clock already runs when it is picked
        for (int s = 0; s < 3; s++) begin
            apb(scd_pkg::SRC_DIV_ADDR, 1'b1, {6'h04, 2'(s)});
            meas;
            meas;
            chk(hi, 2 << s);
            chk(lo, 2 << s);
        end
        repeat (8) begin
            @(posedge core_clk);
            lag = cyc - 3'h2;
            chk(extSync, lag[1]);
        end
        chk(fastEn, 1'b0);
        fastReq <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(fastEn, 1'b1);
        fastReq <= 1'b0;
        $display("test select done");
    endtask
    task automatic t_capture;
        capMode <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            apb(scd_pkg::SLOW_CTRL_ADDR, 1'b1, {6'h20, 2'(c)});
            if (c == 4) capMode <= 1'b0;
            repeat (64) @(posedge core_clk);
            n = 0;
            repeat (128) begin
                @(posedge core_clk);
                n += int'(capEv);
            end
            chk(n, c == 4 ? 0 : 16 >> c);
        end
        $display("test capture done");
    endtask
    // reset again in mid-run: trim and selection return to their reset values
    task automatic t_rereset;
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(trim, 8'h80);
        rst_b <= 1'b1;
        apb(scd_pkg::SRC_DIV_ADDR, 1'b0, 8'h0);
        chk(rd, 8'h30);
        chk(fastEn, 1'b1);
        $display("test second reset done");
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        results;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_divide;
        t_select;
        t_capture;
        t_rereset;
        results;
    end
endmodule
`default_nettype wire
